// >>> srw_consts.vh
// Constants for the supply reset watchdog supervisor.
`ifndef SRW_CONSTS_VH
`define SRW_CONSTS_VH
// =====================================================================
// Timing
// =====================================================================
`define SRW_CLK_HZ         25000000
`define SRW_CLK_NS         40
`define SRW_RST_MS         200
`define SRW_WD_MS          1600
`define SRW_KICK_NS        50
`define SRW_RST_CYC        (`SRW_CLK_HZ / 1000 * `SRW_RST_MS)
`define SRW_WD_CYC         (`SRW_CLK_HZ / 1000 * `SRW_WD_MS)
`define SRW_KICK_CYC       ((`SRW_KICK_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)
`define SRW_CNT_W          26
`define SRW_KCNT_W         4
`endif

// >>> srw_sync.v
// Two-stage synchroniser for a group of single-bit levels.
`default_nettype none
module srw_sync #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         clk_en,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
    end else if (clk_en) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule
`default_nettype wire

// >>> srw_supervisor.v
// Supply reset and watchdog supervisor core logic.
// Summary of operation
// - Aux-low flag follows the aux comparator directly, ignoring all timers.
// - Floating kick input holds watchdog timer in reset, output high unless supply-low.
// - Watchdog timer stays inactive while system reset is low.
// - Kick level change wider than minimum width starts or restarts timer.
// - No kick within timeout stops timer and drives watchdog output low.
// - Kick after timeout returns watchdog output high and restarts timer.
// - Power-up: watchdog output low during supply-low, high once restored.
// - Watchdog timer activates only after system reset is released.
// - Supply-low forces watchdog output and system reset low together.
// - Supply restored starts reset countdown; reset released when done.
// - Supply-low during countdown clears it; full restart after recovery.
// - Supply-low asserts system reset and holds it while it persists.
// - Manual reset low forces system reset low and clears reset timer.
// - Manual reset release starts full countdown before reset release.
// - With kick floating, watchdog output follows only the supply monitor.
`default_nettype none
`include "srw_consts.vh"
module srw_supervisor #(
  parameter [25:0] RST_CYC = `SRW_RST_CYC,
  parameter [25:0] WD_CYC  = `SRW_WD_CYC
) (
  input  wire clk,
  input  wire reset_n,
  input  wire clk_en,
  input  wire supply_low,
  input  wire aux_voltage_sense,
  input  wire manual_reset_in_n,
  input  wire watchdog_kick_in,
  input  wire watchdog_kick_float,
  output wire aux_voltage_low_n,
  output wire watchdog_expired_n,
  output wire system_reset_n
);
  // ===================================================================
  // Input synchronisation
  // ===================================================================
  // aux_voltage_sense is high when the sensed input is above reference.
  wire [4:0] sync_w;
  // The kick stage resets low to match the kick reference, so leaving
  // reset never looks like a level change on the kick pin.
  srw_sync #(.W(5), .INIT(5'h16)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       ({watchdog_kick_float, watchdog_kick_in, manual_reset_in_n,
                aux_voltage_sense, supply_low}),
    .q       (sync_w)
  );
  wire sup_low = sync_w[0];
  wire aux_ok  = sync_w[1];
  wire mr_n    = sync_w[2];
  wire kick    = sync_w[3];
  wire kfloat  = sync_w[4];

  // ===================================================================
  // Output and state registers
  // ===================================================================
  reg aux_low_n_q;
  reg sys_rst_n_q;
  reg wdo_n_q;
  reg wd_run_q;
  reg [`SRW_CNT_W-1:0] rst_cnt_q;
  reg [`SRW_CNT_W-1:0] wd_cnt_q;
  reg kick_ref_q;
  reg [`SRW_KCNT_W-1:0] kcnt_q;

  assign aux_voltage_low_n  = aux_low_n_q;
  assign system_reset_n     = sys_rst_n_q;
  assign watchdog_expired_n = wdo_n_q;

  // ===================================================================
  // Kick width filter
  // ===================================================================
  // A new level only counts once it has stood for the minimum width, so
  // glitches shorter than that never restart the timer.
  wire kick_diff = (kick != kick_ref_q);
  wire kick_evt  = kick_diff && !kfloat &&
                   (kcnt_q >= (`SRW_KICK_CYC - 1));

  always @(posedge clk) begin
    if (!reset_n) begin
      kick_ref_q <= 1'b0;
      kcnt_q     <= 4'h0;
    end else if (clk_en) begin
      if (!kick_diff || kfloat) begin
        kcnt_q <= 4'h0;
      end else if (kick_evt) begin
        kick_ref_q <= kick;
        kcnt_q     <= 4'h0;
      end else begin
        kcnt_q <= kcnt_q + 4'h1;
      end
    end
  end

  // ===================================================================
  // Shared counter helpers
  // ===================================================================
  // Both timers act on the match one edge later, so the compare stops
  // one count short of the terminal value. A terminal count of zero is
  // not supported: the subtraction would wrap and the timer runs the whole counter range.
  function at_term;
    input [`SRW_CNT_W-1:0] cnt;
    input [`SRW_CNT_W-1:0] term;
    begin
      at_term = (cnt >= term - 26'h0000001);
    end
  endfunction

  // One step of either timer, kept at the counter width.
  function [`SRW_CNT_W-1:0] cnt_step;
    input [`SRW_CNT_W-1:0] cnt;
    begin
      cnt_step = cnt + 26'h0000001;
    end
  endfunction

  // ===================================================================
  // Reset timer
  // ===================================================================
  // The host treats a low reset line as reset, so brownout must win.
  wire rst_hold = sup_low || !mr_n;

  reg                  aux_low_n_d;
  reg                  sys_rst_n_d;
  reg [`SRW_CNT_W-1:0] rst_cnt_d;

  always @* begin
    aux_low_n_d = aux_ok;
    sys_rst_n_d = sys_rst_n_q;
    rst_cnt_d   = rst_cnt_q;
    if (rst_hold) begin
      sys_rst_n_d = 1'b0;
      rst_cnt_d   = 26'h0000000;
    end else if (!sys_rst_n_q) begin
      if (at_term(rst_cnt_q, RST_CYC)) begin
        sys_rst_n_d = 1'b1;
      end else begin
        rst_cnt_d = cnt_step(rst_cnt_q);
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      aux_low_n_q <= 1'b1;
      sys_rst_n_q <= 1'b0;
      rst_cnt_q   <= 26'h0000000;
    end else if (clk_en) begin
      aux_low_n_q <= aux_low_n_d;
      sys_rst_n_q <= sys_rst_n_d;
      rst_cnt_q   <= rst_cnt_d;
    end
  end

  // ===================================================================
  // Watchdog timer
  // ===================================================================
  reg                  wdo_n_d;
  reg                  wd_run_d;
  reg [`SRW_CNT_W-1:0] wd_cnt_d;

  // Priority is brownout, then disable or reset, then a fresh kick, then
  // the running count. A kick in the timeout cycle wins, so a host that
  // kicks right at the limit never sees a spurious expiry.
  always @* begin
    wdo_n_d  = wdo_n_q;
    wd_run_d = wd_run_q;
    wd_cnt_d = wd_cnt_q;
    if (sup_low) begin
      wdo_n_d  = 1'b0;
      wd_run_d = 1'b0;
      wd_cnt_d = 26'h0000000;
    end else if (kfloat || !sys_rst_n_q) begin
      wdo_n_d  = 1'b1;
      wd_run_d = 1'b0;
      wd_cnt_d = 26'h0000000;
    end else if (kick_evt) begin
      wdo_n_d  = 1'b1;
      wd_run_d = 1'b1;
      wd_cnt_d = 26'h0000000;
    end else if (wd_run_q) begin
      if (at_term(wd_cnt_q, WD_CYC)) begin
        wdo_n_d  = 1'b0;
        wd_run_d = 1'b0;
      end else begin
        wd_cnt_d = cnt_step(wd_cnt_q);
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      wdo_n_q  <= 1'b0;
      wd_run_q <= 1'b0;
      wd_cnt_q <= 26'h0000000;
    end else if (clk_en) begin
      wdo_n_q  <= wdo_n_d;
      wd_run_q <= wd_run_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end
endmodule
`default_nettype wire

// >>> srw_properties.sv
// Checker of the supervisor outputs against their causes.
`default_nettype none
module srw_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic supply_low,
  input wire logic aux_voltage_sense,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_float,
  input wire logic aux_voltage_low_n,
  input wire logic watchdog_expired_n,
  input wire logic system_reset_n
);
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_aux; aux_voltage_low_n == $past(aux_voltage_sense, 3);
  endproperty
  a_aux: assert property (p_aux) else $error("bad aux flag");
  property p_sl; $past(supply_low, 3) |-> !watchdog_expired_n
    && !system_reset_n; endproperty
  a_sl: assert property (p_sl) else $error("bad low supply");
  property p_mr; !$past(manual_reset_in_n, 3) |-> !system_reset_n;
  endproperty
  a_mr: assert property (p_mr) else $error("bad manual reset");
  property p_len; $rose(system_reset_n) |-> !$past(system_reset_n, 18);
  endproperty
  a_len: assert property (p_len) else $error("short reset");
  property p_why; $rose(system_reset_n) |-> $past(manual_reset_in_n, 3)
    && !$past(supply_low, 3); endproperty
  a_why: assert property (p_why) else $error("bad release");
  property p_flt; $past(watchdog_kick_float, 3) && !$past(supply_low, 3)
    |-> watchdog_expired_n; endproperty
  a_flt: assert property (p_flt) else $error("bad float");
  property p_pwr; $past(supply_low, 4) && !$past(supply_low, 3)
    |-> watchdog_expired_n; endproperty
  a_pwr: assert property (p_pwr) else $error("bad power up");
  property p_tmo; $fell(watchdog_expired_n) && !$past(supply_low, 3)
    |-> $past(system_reset_n, 45) && $past(watchdog_expired_n, 40);
  endproperty
  a_tmo: assert property (p_tmo) else $error("early time-out");
  c_rst: cover property ($rose(system_reset_n));
  c_wd: cover property ($fell(watchdog_expired_n) && system_reset_n);
  c_aux: cover property ($fell(aux_voltage_low_n));
endmodule
bind srw_supervisor srw_props u_props (.clk, .reset_n, .supply_low,
  .aux_voltage_sense, .manual_reset_in_n, .watchdog_kick_float,
  .aux_voltage_low_n, .watchdog_expired_n, .system_reset_n);
`default_nettype wire

// >>> srw_host.sv
// Host model that kicks the watchdog while out of reset.
`default_nettype none
module srw_host (
  input  wire logic clk,
  input  wire logic system_reset_n,
  input  wire logic kick_en,
  output var  logic kick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'h0;
  initial kick = 1'b0;
  // Kick levels last 16 cycles, well above the minimum width.
  always @(negedge clk) begin
    cnt_q <= cnt_q + 4'h1;
    if (kick_en && system_reset_n && cnt_q == 4'hF) kick <= !kick;
  end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the supervisor.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, sl = 0, aux = 1, mr_n = 1, flt = 0, ken = 0;
  logic cen = 1, k0;
  wire kick, aux_n, wdo_n, rst_n;
  int miscompares = 0, checks = 0, n;
  srw_supervisor #(.RST_CYC(26'h14), .WD_CYC(26'h32)) dut (.clk(clk),
    .reset_n(reset_n), .clk_en(cen), .supply_low(sl),
    .aux_voltage_sense(aux), .manual_reset_in_n(mr_n),
    .watchdog_kick_in(kick), .watchdog_kick_float(flt),
    .aux_voltage_low_n(aux_n), .watchdog_expired_n(wdo_n),
    .system_reset_n(rst_n));
  srw_host host (.clk(clk), .system_reset_n(rst_n), .kick_en(ken),
    .kick(kick));
  // ====
  // Tasks
  task final_report;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(string nm, logic s, logic e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  // Bounded wait on reset (sel 0), watchdog (sel 1) or kick (sel 2); n counts cycles.
  task wt(int sel, logic v, int lim);
    n = 0;
    while ((sel == 2 ? kick : sel == 1 ? wdo_n : rst_n) !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        miscompares++;
        final_report;
      end
    end
  endtask
  task t_brown;
    sl = 1;
    repeat (4) @(negedge clk);
    chk("rst", rst_n, 0);
    chk("wdo", wdo_n, 0);
    sl = 0;
    repeat (10) @(negedge clk);
    chk("rst", rst_n, 0);
    sl = 1;
    repeat (4) @(negedge clk);
    sl = 0;
    wt(0, 1, 40);
    chk("rst len", n > 19, 1);
  endtask
  task t_mr;
    mr_n = 0;
    repeat (80) @(negedge clk);
    chk("rst", rst_n, 0);
    chk("wdo", wdo_n, 1);
    mr_n = 1;
    wt(0, 1, 40);
    chk("rst len", n > 19, 1);
  endtask
  task t_wd;
    ken = 1;
    repeat (150) @(negedge clk);
    chk("wdo", wdo_n, 1);
    k0 = kick;
    wt(2, !k0, 20);
    ken = 0;
    wt(1, 0, 90);
    chk("wd len", n > 45, 1);
    ken = 1;
    wt(1, 1, 40);
    chk("wdo", wdo_n, 1);
  endtask
  task t_flt;
    ken = 0;
    flt = 1;
    repeat (80) @(negedge clk);
    chk("wdo", wdo_n, 1);
    sl = 1;
    repeat (4) @(negedge clk);
    chk("wdo", wdo_n, 0);
    sl = 0;
    repeat (4) @(negedge clk);
    chk("wdo", wdo_n, 1);
  endtask
  task t_aux;
    aux = 0;
    repeat (4) @(negedge clk);
    chk("aux", aux_n, 0);
    aux = 1;
    repeat (4) @(negedge clk);
    chk("aux", aux_n, 1);
  endtask
  task t_cen;
    mr_n = 0;
    repeat (8) @(negedge clk);
    mr_n = 1;
    repeat (2) @(negedge clk);
    cen = 0;
    repeat (40) @(negedge clk);
    chk("rst frozen", rst_n, 0);
    cen = 1;
    wt(0, 1, 40);
    chk("rst len", n > 19, 1);
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1;
    wt(0, 1, 60);
    t_brown;
    t_mr;
    t_wd;
    t_flt;
    t_aux;
    t_cen;
    final_report;
  end
endmodule
`default_nettype wire
